// ---- src/conv_ctrl_pkg.sv ----
// Package with register map, field positions, reset values and sequencer states of the converter control block.
package conv_ctrl_pkg;

  // ****************************************************************
  // Register byte offsets on the peripheral bus.
  // ****************************************************************
  localparam logic [7:0] OFS_CTL0      = 8'h00;
  localparam logic [7:0] OFS_CTL1      = 8'h04;
  localparam logic [7:0] OFS_RESULT    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

  // ****************************************************************
  // Field positions of the first control register.
  // ****************************************************************
  localparam int CTL0_SOFT_START   = 0;
  localparam int CTL0_CONV_ENABLE  = 1;
  localparam int CTL0_DONE_FLAG    = 2;
  localparam int CTL0_IRQ_ENABLE   = 3;
  localparam int CTL0_POWER_ON     = 4;
  localparam int CTL0_REF_ON       = 5;
  localparam int CTL0_REF_LEVEL    = 6;
  localparam int CTL0_MULTI_SAMPLE = 7;

  // ****************************************************************
  // Field positions of the second control register.
  // ****************************************************************
  localparam int CTL1_BUSY     = 0;
  localparam int CTL1_SEQ_LO   = 1;
  localparam int CTL1_CSRC_LO  = 3;
  localparam int CTL1_DIV_LO   = 5;
  localparam int CTL1_INVERT   = 8;
  localparam int CTL1_FORMAT   = 9;
  localparam int CTL1_TRIG_LO  = 10;
  localparam int CTL1_CHAN_LO  = 12;

  // ****************************************************************
  // Reset values and codes.
  // ****************************************************************
  localparam logic [15:0] CTL0_RESET     = 16'h0000;
  localparam logic [15:0] CTL1_RESET     = 16'h0000;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0]  TRIG_SOFT      = 2'h0;
  localparam logic [1:0]  SEQ_SINGLE     = 2'h0;
  localparam logic [1:0]  SEQ_ONE_PASS   = 2'h1;
  localparam logic [1:0]  SEQ_REP_SINGLE = 2'h2;
  localparam logic [1:0]  SEQ_REP_SEQ    = 2'h3;
  localparam logic [3:0]  CHAN_LAST      = 4'h0;
  localparam logic [9:0]  TWOS_FLIP      = 10'h200;

  // Sticky event bits of the interrupt status register.
  localparam int EV_RESULT  = 0;
  localparam int EV_SEQ_END = 1;
  localparam int EV_OVERRUN = 2;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_NEXT = 4'b0100,
    ST_WAIT = 4'b1000
  } seq_state_t;

endpackage

// ---- src/conv_ctrl.sv ----
// Control and status register logic with conversion sequencer for a 10-bit converter core.
//
// Behaviour
// - Multi-sample: later conversions start after previous finishes.
// - Done flag sets when result register loads.
// - Done flag clears on accept or zero write.
// - Under block transfer, flag sets at block end.
// - Enable plus start in one write starts conversion.
// - Soft start bit clears itself.
// - Second control register frozen while enable is one.
// - Channel field picks single conversion input.
// - Trigger field: software start or timer outputs.
// - Format bit: straight binary or two's complement.
// - Invert bit inverts selected timer trigger.
// - Divider field divides conversion clock by value+1.
// - Clock source field picks one of four clocks.
// - Sequence field selects one of four modes.
// - Busy reads one while the sequencer is not idle.
`timescale 1ns/1ns
module conv_ctrl
#(
  parameter int CHAN_W = 4,
  parameter int RES_W  = 10
)
(
  input  wire logic                         clock_i,
  input  wire logic                         srst_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [7:0]                   paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  output logic      [31:0]                  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  input  wire logic [2:0]                   timer_trig_i,
  input  wire logic [3:0]                   clk_src_tick_i,
  input  wire logic                         conv_done_i,
  input  wire logic [RES_W-1:0]             conv_data_i,
  input  wire logic                         block_xfer_active_i,
  input  wire logic                         block_xfer_done_i,
  input  wire logic                         irq_accept_i,
  output logic                              start_conv_o,
  output logic      [CHAN_W-1:0]            channel_o,
  output logic                              conv_clk_en_o,
  output logic                              power_on_o,
  output logic                              ref_on_o,
  output logic                              ref_level_o,
  output logic                              busy_o,
  output logic                              conv_irq_o,
  output logic                              irq_o
);
  import conv_ctrl_pkg::*;

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [7:0]        ctl0_high_r;
  logic              multi_sample_conv_r;
  logic              ref_level_select_r;
  logic              ref_generator_on_r;
  logic              converter_power_on_r;
  logic              conv_irq_enable_r;
  logic              conv_done_flag_r;
  logic              conv_enable_r;
  logic              soft_start_conv_r;
  logic [CHAN_W-1:0] channel_select_r;
  logic [1:0]        trigger_source_select_r;
  logic              result_format_r;
  logic              trigger_invert_r;
  logic [2:0]        conv_clock_divider_r;
  logic [1:0]        conv_clock_source_r;
  logic [1:0]        sequence_mode_r;
  logic [15:0]       result_register_r;
  logic [2:0]        irq_stat_r;
  logic [2:0]        irq_mask_r;
  logic              trig_q_r;
  logic [2:0]        div_cnt_r;
  logic [CHAN_W-1:0] cur_chan_r;
  seq_state_t        state_r;
  seq_state_t        state_nxt;
  logic              trig_level;
  logic              trig_rise;
  logic              bus_access;
  logic              wr_fire;
  logic              rd_hit;
  logic [31:0]       rd_data;
  logic              wr_ctl0;
  logic              wr_ctl1;
  logic              result_load;
  logic              seq_end;
  logic              done_set;
  logic              start_now;
  logic              src_tick;
  logic [15:0]       ctl0_view;
  logic [15:0]       ctl1_view;

  // ****************************************************************
  // APB slave: one wait state, then pready with registered data.
  // ****************************************************************

  // The access phase is answered on its second cycle so read data comes from a flop.
  assign bus_access = psel_i & penable_i;
  assign wr_fire    = bus_access & pready_o & pwrite_i;
  assign wr_ctl0    = wr_fire & (paddr_i == OFS_CTL0);
  assign wr_ctl1    = wr_fire & (paddr_i == OFS_CTL1);

  // Register views as software sees them.
  assign ctl0_view = {ctl0_high_r, multi_sample_conv_r, ref_level_select_r, ref_generator_on_r,
                      converter_power_on_r, conv_irq_enable_r, conv_done_flag_r, conv_enable_r,
                      soft_start_conv_r};
  assign ctl1_view = {channel_select_r, trigger_source_select_r, result_format_r, trigger_invert_r,
                      conv_clock_divider_r, conv_clock_source_r, sequence_mode_r,
                      state_r != ST_IDLE};

  // Read multiplexer; unmapped addresses read zero and flag an error.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr_i)
      OFS_CTL0:     rd_data = {16'h0000, ctl0_view};
      OFS_CTL1:     rd_data = {16'h0000, ctl1_view};
      OFS_RESULT:   rd_data = {16'h0000, result_register_r};
      OFS_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat_r};
      OFS_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask_r};
      default:      rd_hit  = 1'b0;
    endcase
  end

  // Bus answer flops.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      {pready_o, prdata_o, pslverr_o} <= '0;
    else
    begin
      pready_o  <= bus_access & ~pready_o;
      prdata_o  <= (bus_access & ~pready_o & ~pwrite_i) ? rd_data : 32'h0000_0000;
      pslverr_o <= bus_access & ~pready_o & ~rd_hit;
    end
  end

  // ****************************************************************
  // First control register.
  // ****************************************************************

  // Plain read/write fields of the first control register.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      {ctl0_high_r, multi_sample_conv_r, ref_level_select_r, ref_generator_on_r,
       converter_power_on_r, conv_irq_enable_r, conv_enable_r} <= {CTL0_RESET[15:3], CTL0_RESET[1]};
    end
    else if (wr_ctl0)
    begin
      ctl0_high_r          <= pwdata_i[15:8];
      multi_sample_conv_r  <= pwdata_i[CTL0_MULTI_SAMPLE];
      ref_level_select_r   <= pwdata_i[CTL0_REF_LEVEL];
      ref_generator_on_r   <= pwdata_i[CTL0_REF_ON];
      converter_power_on_r <= pwdata_i[CTL0_POWER_ON];
      conv_irq_enable_r    <= pwdata_i[CTL0_IRQ_ENABLE];
      conv_enable_r        <= pwdata_i[CTL0_CONV_ENABLE];
    end
  end

  // Software start lives one cycle only; it is seen together with the enable written beside it.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      soft_start_conv_r <= CTL0_RESET[CTL0_SOFT_START];
    else
      soft_start_conv_r <= wr_ctl0 & pwdata_i[CTL0_SOFT_START];
  end

  // Done flag: a new result (or block end) wins over a clear in the same cycle.
  assign done_set = block_xfer_active_i ? block_xfer_done_i : result_load;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      conv_done_flag_r <= CTL0_RESET[CTL0_DONE_FLAG];
    else if (done_set)
      conv_done_flag_r <= 1'b1;
    else if (irq_accept_i)
      conv_done_flag_r <= 1'b0;
    else if (wr_ctl0)
      conv_done_flag_r <= pwdata_i[CTL0_DONE_FLAG];
  end

  // ****************************************************************
  // Second control register.
  // ****************************************************************

  // Settings may only change while conversions are disabled; the gate is the enable bit, not busy, so a sequence still running after enable drops can see them move.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      {channel_select_r, trigger_source_select_r, result_format_r, trigger_invert_r,
       conv_clock_divider_r, conv_clock_source_r, sequence_mode_r} <= CTL1_RESET[15:1];
    else if (wr_ctl1 && !conv_enable_r)
    begin
      channel_select_r        <= pwdata_i[CTL1_CHAN_LO +: CHAN_W];
      trigger_source_select_r <= pwdata_i[CTL1_TRIG_LO +: 2];
      result_format_r         <= pwdata_i[CTL1_FORMAT];
      trigger_invert_r        <= pwdata_i[CTL1_INVERT];
      conv_clock_divider_r    <= pwdata_i[CTL1_DIV_LO +: 3];
      conv_clock_source_r     <= pwdata_i[CTL1_CSRC_LO +: 2];
      sequence_mode_r         <= pwdata_i[CTL1_SEQ_LO +: 2];
    end
  end

  // ****************************************************************
  // Conversion clock: selected source tick divided by field plus one.
  // ****************************************************************

  assign src_tick = clk_src_tick_i[conv_clock_source_r];

  // The enable pulse goes out on every (divider+1)-th tick of the chosen source.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      {div_cnt_r, conv_clk_en_o} <= '0;
    else
    begin
      conv_clk_en_o <= 1'b0;
      if (src_tick)
      begin
        if (div_cnt_r >= conv_clock_divider_r)
        begin
          div_cnt_r     <= 3'h0;
          conv_clk_en_o <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Trigger selection and edge detection.
  // ****************************************************************

  // Code zero is the software start, the others the three timer outputs.
  assign trig_level = (trigger_source_select_r == TRIG_SOFT) ? soft_start_conv_r :
                      timer_trig_i[2'(trigger_source_select_r - 2'h1)] ^ trigger_invert_r;

  // The software start is already a pulse; inverting it would make a level that never ends.
  assign trig_rise = trig_level & ~trig_q_r;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      trig_q_r <= 1'b0;
    else
      trig_q_r <= trig_level;
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************

  assign result_load = (state_r == ST_CONV) & conv_done_i;
  assign start_now   = conv_enable_r & trig_rise;

  // End of a pass: single mode, last channel of a one-shot sequence, or enable dropped in a repeat mode.
  assign seq_end = (sequence_mode_r == SEQ_SINGLE) ||
                   ((sequence_mode_r == SEQ_ONE_PASS) ? (cur_chan_r == CHAN_LAST) : !conv_enable_r);

  // Next-state logic; a new conversion after the first is started by multi-sample or a new trigger edge.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (start_now)
          state_nxt = ST_CONV;
      ST_CONV:
        if (conv_done_i)
          state_nxt = seq_end ? ST_IDLE : ST_NEXT;
      ST_NEXT:
        state_nxt = multi_sample_conv_r ? ST_CONV : ST_WAIT;
      ST_WAIT:
        if (!conv_enable_r)
          state_nxt = ST_IDLE;
        else if (trig_rise)
          state_nxt = ST_CONV;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Channel pointer: loads the field on a fresh start, steps down in sequence modes and wraps in repeat.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      cur_chan_r <= CTL1_RESET[CTL1_CHAN_LO +: CHAN_W];
    else if (state_r == ST_IDLE)
      cur_chan_r <= channel_select_r;
    else if (result_load && sequence_mode_r[0])
    begin
      if (cur_chan_r == CHAN_LAST)
        cur_chan_r <= channel_select_r;
      else
        cur_chan_r <= cur_chan_r - 1'b1;
    end
  end

  // One start pulse per conversion, aligned with the channel it converts.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      {start_conv_o, channel_o, busy_o} <= '0;
    else
    begin
      start_conv_o <= (state_nxt == ST_CONV) && (state_r != ST_CONV);
      channel_o    <= (state_r == ST_IDLE) ? channel_select_r : cur_chan_r;
      busy_o       <= state_nxt != ST_IDLE;
    end
  end

  // ****************************************************************
  // Result register.
  // ****************************************************************

  // Binary is right-justified; two's complement flips the top bit and left-justifies.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      result_register_r <= 16'h0000;
    else if (result_load)
    begin
      if (result_format_r)
        result_register_r <= {conv_data_i ^ TWOS_FLIP, 6'h00};
      else
        result_register_r <= {6'h00, conv_data_i};
    end
  end

  // ****************************************************************
  // Interrupts.
  // ****************************************************************

  // Sticky events, cleared by writing one; a new event in the clearing cycle survives.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      irq_stat_r <= 3'h0;
    else
    begin
      irq_stat_r[EV_RESULT]  <= result_load | (irq_stat_r[EV_RESULT] &
                                ~(wr_fire & (paddr_i == OFS_IRQ_STAT) & pwdata_i[EV_RESULT]));
      irq_stat_r[EV_SEQ_END] <= (result_load & seq_end) | (irq_stat_r[EV_SEQ_END] &
                                ~(wr_fire & (paddr_i == OFS_IRQ_STAT) & pwdata_i[EV_SEQ_END]));
      irq_stat_r[EV_OVERRUN] <= (trig_rise & (state_r == ST_CONV)) | (irq_stat_r[EV_OVERRUN] &
                                ~(wr_fire & (paddr_i == OFS_IRQ_STAT) & pwdata_i[EV_OVERRUN]));
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      irq_mask_r <= IRQ_MASK_RESET;
    else if (wr_fire && paddr_i == OFS_IRQ_MASK)
      irq_mask_r <= pwdata_i[2:0];
  end

  // Both requests are registered, so they trail their cause by one cycle.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      {irq_o, conv_irq_o, power_on_o, ref_on_o, ref_level_o} <= '0;
    else
    begin
      irq_o       <= |(irq_stat_r & irq_mask_r);
      conv_irq_o  <= conv_done_flag_r & conv_irq_enable_r & ~irq_accept_i;
      power_on_o  <= converter_power_on_r;
      ref_on_o    <= ref_generator_on_r;
      ref_level_o <= ref_level_select_r;
    end
  end

endmodule

// ---- testbench/conv_core_model.sv ----
// Behavioural converter core that answers each start request after a set latency.
`timescale 1ns/1ns
module conv_core_model
(
  input  wire logic       clock_i,
  input  wire logic       start_i,
  input  wire logic [3:0] channel_i,
  input  wire logic [3:0] lat_i,
  output logic            done_o,
  output logic      [9:0] data_o
);
  int         cnt = 0;
  logic [3:0] ch_r = 4'h0;

  // Result data is valid only with the done pulse; it toggles otherwise so stale data is never mistaken.
  always @(posedge clock_i)
  begin
    done_o <= (start_i !== 1'b1) && (cnt == 1);
    data_o <= (start_i !== 1'b1 && cnt == 1) ? {ch_r, 6'h25} : ~data_o;
    if (start_i === 1'b1)
    begin
      cnt = lat_i;
      ch_r <= channel_i;
    end
    else if (cnt > 0)
      cnt--;
  end

  // Quiet outputs before the first edge.
  initial
  begin
    done_o = 1'b0;
    data_o = 10'h000;
  end
endmodule

// ---- testbench/conv_ctrl_sva.sv ----
// Port-level checker of the converter control block.
`timescale 1ns/1ns
module conv_ctrl_sva
  import conv_ctrl_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        conv_done_i,
  input wire logic        block_xfer_active_i,
  input wire logic        irq_accept_i,
  input wire logic        start_conv_o,
  input wire logic        busy_o,
  input wire logic        conv_irq_o
);
  logic       wr0;
  logic       wr1;
  logic       en_r;
  logic       ie_r;
  logic       ms_r;
  logic [1:0] trig_r;
  logic [1:0] seq_r;
  logic [1:0] off_cnt_r;

  // Writes as committed at the edge that ends the access.
  assign wr0 = psel_i && penable_i && pwrite_i && pready_o && paddr_i == OFS_CTL0;
  assign wr1 = psel_i && penable_i && pwrite_i && pready_o && paddr_i == OFS_CTL1;

  // Shadow of the control bits; the second register is frozen while enabled, just as in the block.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      {ms_r, ie_r, en_r, trig_r, seq_r} <= '0;
    else
    begin
      if (wr0)
        {ms_r, ie_r, en_r} <= {pwdata_i[7], pwdata_i[3], pwdata_i[1]};
      if (wr1 && !en_r)
        {trig_r, seq_r} <= {pwdata_i[11:10], pwdata_i[2:1]};
    end
  end

  // Cycles since enable fell, saturating once in-flight triggers have drained.
  always_ff @(posedge clock_i)
  begin
    if (srst_i || en_r)
      off_cnt_r <= 2'h0;
    else if (off_cnt_r != 2'h3)
      off_cnt_r <= off_cnt_r + 2'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  AST_APB_WAIT: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("access did not end after one wait state");
  AST_ERR_READY: assert property (pslverr_o |-> pready_o)
    else $error("error response without ready");
  AST_START_PULSE: assert property (start_conv_o |=> !start_conv_o)
    else $error("start pulse longer than one cycle");
  AST_SOFT_START: assert property (wr0 && pwdata_i[1:0] == 2'h3 && trig_r == TRIG_SOFT && !busy_o |-> ##[1:4] start_conv_o)
    else $error("enable with software start did not start a conversion");
  AST_BUSY: assert property (start_conv_o |-> ##[0:2] busy_o)
    else $error("busy low during a conversion");
  AST_NO_START_OFF: assert property (off_cnt_r == 2'h3 && !busy_o && !$past(busy_o) |-> !start_conv_o)
    else $error("conversion started while disabled");
  AST_ACCEPT: assert property (irq_accept_i |=> !conv_irq_o)
    else $error("request stayed high after acceptance");
  AST_DONE_IRQ: assert property (conv_done_i && busy_o && ie_r && !block_xfer_active_i && !irq_accept_i |-> ##[1:2] conv_irq_o)
    else $error("result load did not raise the request");
  AST_MULTI: assert property (conv_done_i && busy_o && ms_r && en_r && seq_r == SEQ_REP_SINGLE |-> ##[1:4] start_conv_o)
    else $error("next conversion did not follow automatically");

  COV_MULTI: cover property (conv_done_i && ms_r && busy_o);
  COV_ACCEPT: cover property (irq_accept_i && conv_irq_o);
  COV_REFUSED: cover property (pslverr_o);
endmodule

// ---- testbench/adc_control_register_logic_tb.sv ----
// Self-checking testbench of the converter control block.
`timescale 1ns/1ns
module adc_control_register_logic_tb;
  import conv_ctrl_pkg::*;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [2:0]  timer_trig_i = 3'h0;
  logic [3:0]  clk_src_tick_i = 4'h0;
  logic        block_xfer_active_i = 1'b0;
  logic        block_xfer_done_i = 1'b0;
  logic        irq_accept_i = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, conv_done_i, start_conv_o, conv_clk_en_o, busy_o, conv_irq_o, irq_o;
  logic [9:0]  conv_data_i;
  logic [3:0]  channel_o, ch, lat = 4'h5;
  logic [3:0]  chq[$];
  logic [31:0] q;
  logic [15:0] v;
  logic [2:0]  d, pwr;
  logic        e;
  int          c;
  int          error_cnt = 0;
  int          n_tests = 0;

  always #5 clock_i = ~clock_i;

  conv_ctrl conv_ctrl_i
  (
    .clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .timer_trig_i, .clk_src_tick_i, .conv_done_i, .conv_data_i, .block_xfer_active_i, .block_xfer_done_i,
    .irq_accept_i, .start_conv_o, .channel_o, .conv_clk_en_o, .power_on_o(pwr[0]), .ref_on_o(pwr[1]),
    .ref_level_o(pwr[2]),
    .busy_o, .conv_irq_o, .irq_o
  );

  conv_core_model conv_core_model_i
  (
    .clock_i, .start_i(start_conv_o), .channel_i(channel_o), .lat_i(lat), .done_o(conv_done_i),
    .data_o(conv_data_i)
  );

  // Log the channel of every start, as the core sees it.
  always @(posedge clock_i)
    if (start_conv_o === 1'b1)
      chq.push_back(channel_o);

  function automatic logic [15:0] res_exp(logic [3:0] c4, logic f);
    return f ? {{c4, 6'h25} ^ TWOS_FLIP, 6'h00} : {6'h00, c4, 6'h25};
  endfunction

  function automatic logic [3:0] exp_ch(int m, logic [3:0] c4, int k);
    return (m == 2) ? c4 : c4 - 4'(k % (int'(c4) + 1));
  endfunction

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer with an idle cycle after it, so no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] dt);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {16'h0000, dt};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready_o));
    if (pready_o !== 1'b1)
      complete_run();
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk("read", {16'h0000, exp}, q);
  endtask

  // Bounded wait on start count (k > 0) or on idle (k == 0).
  task automatic wait_for(input int k);
    int n;
    n = 0;
    repeat (3) @(posedge clock_i);
    while ((k > 0 ? chq.size() < k : busy_o !== 1'b0) && n < 600)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 600)
    begin
      chk("wait", 32'h1, 32'h0);
      complete_run();
    end
  endtask

  task automatic pulse_trig(input int t);
    timer_trig_i[t / 2 - 1] <= ~t[0];
    repeat (4) @(posedge clock_i);
    timer_trig_i <= {3{t[0]}};
    repeat (4) @(posedge clock_i);
  endtask

  task automatic count_en(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge clock_i);
      c += int'(conv_clk_en_o === 1'b1);
    end
  endtask

  // Main sequence: reset values, register access, conversions, interrupts, triggers, clocking.
  initial
  begin
    void'($urandom(32'hD020));
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd(OFS_CTL0, CTL0_RESET);
    rd(OFS_CTL1, CTL1_RESET);
    apb(1'b0, 8'h14, 16'h0000);
    chk("unmapped", 32'h1, {q[30:0], e});
    v = 16'($urandom()) & 16'hF3FF;
    apb(1'b1, OFS_CTL1, v);
    rd(OFS_CTL1, v & 16'hFFFE);
    apb(1'b1, OFS_CTL0, 16'h0002);
    apb(1'b1, OFS_CTL1, ~v & 16'hF3FE);
    rd(OFS_CTL1, v & 16'hFFFE);
    apb(1'b1, OFS_CTL0, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      ch = (i == 3) ? 4'hA : 4'($urandom_range(7));
      lat <= 4'($urandom_range(12, 5));
      apb(1'b1, OFS_CTL1, {ch, 2'h0, i[0], 9'h000});
      chq.delete();
      apb(1'b1, OFS_CTL0, 16'h000B);
      wait_for(1);
      wait_for(0);
      chk("channel", 32'(ch), 32'(chq[0]));
      rd(OFS_CTL0, 16'h000E);
      chk("request", 32'h1, 32'(conv_irq_o));
      rd(OFS_RESULT, res_exp(ch, i[0]));
      if (i[1])
        apb(1'b1, OFS_CTL0, 16'h000A);
      else
        irq_accept_i <= 1'b1;
      @(posedge clock_i);
      irq_accept_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk("request", 32'h0, 32'(conv_irq_o));
      rd(OFS_CTL0, 16'h000A);
      apb(1'b1, OFS_CTL0, 16'h0000);
    end
    chk("irq", 32'h0, 32'(irq_o));
    apb(1'b1, OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge clock_i);
    chk("irq", 32'h1, 32'(irq_o));
    apb(1'b1, OFS_IRQ_STAT, 16'h0007);
    repeat (2) @(posedge clock_i);
    chk("irq", 32'h0, 32'(irq_o));
    rd(OFS_IRQ_STAT, 16'h0000);
    for (int m = 1; m < 4; m++)
    begin
      ch = 4'($urandom_range(3, 1));
      apb(1'b1, OFS_CTL1, {ch, 9'h000, 2'(m), 1'b0});
      chq.delete();
      apb(1'b1, OFS_CTL0, 16'h0083);
      wait_for((m == 1) ? ch + 1 : 5);
      if (m != 1)
        apb(1'b1, OFS_CTL0, 16'h0080);
      wait_for(0);
      if (m == 1)
        chk("pass length", 32'(ch) + 1, 32'(chq.size()));
      foreach (chq[k])
        chk("seq channel", 32'(exp_ch(m, ch, k)), 32'(chq[k]));
      apb(1'b1, OFS_CTL0, 16'h0000);
    end
    for (int t = 2; t < 8; t++)
    begin
      timer_trig_i <= {3{t[0]}};
      apb(1'b1, OFS_CTL1, {4'h1, 2'(t / 2), 1'b0, t[0], 8'h00});
      chq.delete();
      pulse_trig(t);
      apb(1'b1, OFS_CTL0, 16'h0002);
      pulse_trig(t);
      wait_for(0);
      chk("timer starts", 32'h1, 32'(chq.size()));
      apb(1'b1, OFS_CTL0, 16'h0000);
    end
    block_xfer_active_i <= 1'b1;
    apb(1'b1, OFS_CTL1, 16'h0000);
    chq.delete();
    apb(1'b1, OFS_CTL0, 16'h000B);
    wait_for(1);
    wait_for(0);
    rd(OFS_CTL0, 16'h000A);
    block_xfer_done_i <= 1'b1;
    @(posedge clock_i);
    block_xfer_done_i <= 1'b0;
    rd(OFS_CTL0, 16'h000E);
    block_xfer_active_i <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      d = (s == 0) ? 3'h7 : (s == 3) ? 3'h0 : 3'($urandom_range(6, 1));
      apb(1'b1, OFS_CTL0, 16'h0000);
      apb(1'b1, OFS_CTL1, {8'h00, d, 2'(s), 3'h0});
      apb(1'b1, OFS_CTL0, 16'h0070);
      clk_src_tick_i <= 4'(1 << s);
      count_en(48);
      chk("analog", 32'h7, 32'(pwr));
      chk("ticks", 32'h1, 32'(c >= 48 / (d + 1) - 1 && c <= 48 / (d + 1) + 1));
      clk_src_tick_i <= ~4'(1 << s);
      count_en(4);
      count_en(16);
      chk("stray ticks", 32'h0, 32'(c));
      clk_src_tick_i <= 4'h0;
    end
    complete_run();
  end
endmodule

bind conv_ctrl conv_ctrl_sva conv_ctrl_sva_i
(
  .clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .conv_done_i,
  .block_xfer_active_i, .irq_accept_i, .start_conv_o, .busy_o, .conv_irq_o
);
